// file: wdcp_pkg.sv
// Constants, types and state encodings for the watchdog with clock protection.
// Assumes option bytes are static flash values valid from reset release.
package wdcp_pkg;

	// ************************************************************
	// Counter and prescaler
	// ************************************************************
	localparam int          CNT_W          = 14;
	localparam int          PRE_W          = 7;
	localparam logic [13:0] PERIOD_SEL_00  = 14'h03FF;
	localparam logic [13:0] PERIOD_SEL_01  = 14'h0FFF;
	localparam logic [13:0] PERIOD_SEL_10  = 14'h1FFF;
	localparam logic [13:0] PERIOD_SEL_11  = 14'h3FFF;
	localparam logic [13:0] COUNT_RST      = 14'h0000;
	localparam logic [6:0]  PRE_RST        = 7'h00;
	localparam logic [6:0]  PRE_LAST_16    = 7'h0F;
	localparam logic [6:0]  PRE_LAST_128   = 7'h7F;

	// ************************************************************
	// Refresh sequence and option byte fields
	// ************************************************************
	localparam logic [7:0]  REFRESH_FIRST  = 8'h00;
	localparam logic [7:0]  REFRESH_SECOND = 8'hFF;
	localparam int          OPT_START_BIT  = 0;
	localparam int          OPT_PROT_BIT   = 7;
	localparam int          OPT_PERIOD_LSB = 0;
	localparam int          OPT_WINDOW_LSB = 2;

	// Gray coded along reset -> halted -> running
	typedef enum logic [1:0] {
		WDCP_INIT = 2'b00,
		WDCP_HALT = 2'b01,
		WDCP_RUN  = 2'b11
	} wdcp_state_t;

	// Option settings captured once after reset
	typedef struct packed {
		logic       prot_init;
		logic       halt_after_rst;
		logic [1:0] period_sel;
		logic [1:0] window_sel;
	} wdcp_cfg_t;

endpackage : wdcp_pkg

// file: wdcp_tb.sv
// Self-checking bench for the watchdog with clock protection.
// Assumes wdcp_top and wdcp_pkg are compiled first; the bench makes LOCO.
`timescale 1ns/1ps
module testbench;
	import wdcp_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, loco = 1'b0, ratio = 1'b0;
	logic        rwr = 1'b0, swr = 1'b0, awr = 1'b0, pwr = 1'b0;
	logic        ad = 1'b0, pd = 1'b0, wt = 1'b0, st = 1'b0;
	logic [7:0]  om = 8'h81, os = 8'h0C, rd = 8'h00;
	logic        irq, wrst, lon, pen, asel, run, iseen, rseen;
	logic [13:0] cnt, c;
	logic [13:0] per [4];
	int          fail_count = 0, n_compared = 0, cyc = 0, t0;

	// ************************************************************
	// Clocks and design
	// ************************************************************
	always #20 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	// Oscillator runs only while the block switches it on
	always #200 loco = (lon === 1'b1) ? ~loco : 1'b0;

	wdcp_top u_wdcp_top (
		.I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_OPT_MAIN(om),
		.I_OPT_SECOND(os), .I_LOCO_CLK(loco), .I_REFRESH_WR(rwr),
		.I_REFRESH_DATA(rd), .I_START_WR(swr),
		.I_PRESCALER_RATIO_SEL(ratio), .I_ACTION_WR(awr),
		.I_ACTION_DATA(ad), .I_PROT_WR(pwr), .I_PROT_DATA(pd),
		.I_WAIT_MODE(wt), .I_STOP_MODE(st), .O_WDT_IRQ(irq),
		.O_WDT_RST(wrst), .O_LOCO_ON(lon), .O_PROT_EN(pen),
		.O_ACTION_SEL(asel), .O_RUNNING(run), .O_COUNT(cnt));

	// ************************************************************
	// Tasks
	// ************************************************************
	task complete_run;
		if (fail_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	task chk(input string nm, input logic [13:0] e, input logic [13:0] g);
		n_compared++;
		if (g !== e) begin
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
			fail_count++;
		end
	endtask : chk

	task chkb(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			$display("CHECK FAILED %s exp %b got %b", nm, e, g);
			fail_count++;
		end
	endtask : chkb

	// Advance n edges, land just after the last one
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	// One-cycle write strobe: 0 refresh, 1 start, 2 action, 3 protect
	task wr(input int k, input logic [7:0] d);
		@(posedge clk);
		#1;
		rd = d;
		ad = d[0];
		pd = d[0];
		case (k)
			0: rwr = 1'b1;
			1: swr = 1'b1;
			2: awr = 1'b1;
			default: pwr = 1'b1;
		endcase
		@(posedge clk);
		#1;
		{rwr, swr, awr, pwr} = 4'h0;
	endtask : wr

	task refr;
		wr(0, REFRESH_FIRST);
		wr(0, REFRESH_SECOND);
	endtask : refr

	// Wait for the count to move, bounded
	task tick(input int b);
		logic [13:0] p;
		p = cnt;
		for (int i = 0; i < b && cnt === p; i++)
			step(1);
		if (cnt === p) begin
			$display("CHECK FAILED tick_wait exp change got %h", p);
			fail_count++;
			complete_run;
		end
	endtask : tick

	// Collect pulses over n cycles
	task watch(input int n);
		iseen = 1'b0;
		rseen = 1'b0;
		repeat (n) begin
			iseen = iseen | (irq === 1'b1);
			rseen = rseen | (wrst === 1'b1);
			step(1);
		end
	endtask : watch

	task rst_to(input logic [7:0] m, input logic [7:0] s);
		rst_n = 1'b0;
		om = m;
		os = s;
		step(6);
		rst_n = 1'b1;
		step(2);
	endtask : rst_to

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		per = '{PERIOD_SEL_00, PERIOD_SEL_01, PERIOD_SEL_10, PERIOD_SEL_11};
		rst_to(8'h81, 8'h0C);
		step(40);
		chkb("running", 1'b0, run);
		chk("halt_count", PERIOD_SEL_00, cnt);
		wr(1, 8'h00);
		step(1);
		chkb("running", 1'b1, run);
		tick(40);
		c = cnt;
		t0 = cyc;
		tick(40);
		chk("ticks16", 14'h0010, 14'(cyc - t0));
		chk("decrement", c - 14'h0001, cnt);
		tick(40);
		t0 = cyc;
		refr;
		chk("reload", PERIOD_SEL_00, cnt);
		tick(40);
		chk("prescaler", 14'h0010, 14'(cyc - t0));
		chk("after", PERIOD_SEL_00 - 14'h0001, cnt);
		ratio = 1'b1;
		tick(200);
		tick(200);
		t0 = cyc;
		tick(200);
		chk("ticks128", 14'h0080, 14'(cyc - t0));
		c = cnt;
		wr(0, 8'h00);
		wr(0, 8'h55);
		wr(0, 8'hFF);
		wr(0, 8'hFF);
		chk("badseq", c, cnt);
		wt = 1'b1;
		step(300);
		chk("wait", c, cnt);
		wt = 1'b0;
		st = 1'b1;
		step(300);
		chk("stop", c, cnt);
		st = 1'b0;
		tick(200);
		chk("resume", c - 14'h0001, cnt);
		ratio = 1'b0;
		wr(3, 8'h01);
		chkb("prot", 1'b0, pen);
		wr(3, 8'h00);
		wr(3, 8'h01);
		chkb("prot", 1'b1, pen);
		chkb("loco", 1'b1, lon);
		chkb("action", 1'b1, asel);
		wr(3, 8'h00);
		chkb("prot", 1'b1, pen);
		tick(40);
		t0 = cyc;
		tick(40);
		chk("loco_ticks", 14'h000A, 14'(cyc - t0));
		{wt, st} = 2'b11;
		tick(40);
		t0 = cyc;
		tick(40);
		chk("sleep_ticks", 14'h000A, 14'(cyc - t0));
		{wt, st} = 2'b00;
		// Auto start, unprotected, narrowest refresh window
		rst_to(8'h80, 8'h00);
		chkb("running", 1'b1, run);
		chk("auto_load", PERIOD_SEL_00, cnt);
		watch(16500);
		chkb("irq", 1'b1, iseen);
		chkb("rst", 1'b0, rseen);
		refr;
		watch(3);
		chkb("early_irq", 1'b1, iseen);
		wr(2, 8'h01);
		chkb("action", 1'b1, asel);
		refr;
		watch(3);
		chkb("early_rst", 1'b1, rseen);
		chkb("early_irq", 1'b0, iseen);
		// Protection from the option byte
		rst_to(8'h00, 8'h00);
		chkb("prot", 1'b1, pen);
		chkb("loco", 1'b1, lon);
		chk("prot_load", PERIOD_SEL_00, cnt);
		watch(10300);
		chkb("rst", 1'b1, rseen);
		chkb("irq", 1'b0, iseen);
		wr(2, 8'h00);
		chkb("action", 1'b1, asel);
		for (int i = 0; i < 4; i++) begin
			rst_to(8'h81, 8'(i));
			step(2);
			chk("period", per[i], cnt);
		end
		complete_run;
	end
endmodule : testbench

// file: wdcp_top.sv
// Watchdog counter with count source protection, prescaler and refresh window.
// Assumes software write strobes and sleep mode levels come from core-clock
// logic; the low-speed oscillator clock arrives asynchronously.
//
// What this block does
// - Unprotected: count CPU clock through prescaler dividing by 16 or 128.
// - Counter decrements from selected count; 11b=3FFFh, 00b=03FFh.
// - Period field decodes 00/01/10/11 to 03FFh/0FFFh/1FFFh/3FFFh.
// - Counter reloads on reset, underflow, and 00h then FFh refresh inside the window.
// - Prescaler cleared only by reset, never by refresh.
// - Start option 1: counter and prescaler halt until start write.
// - Start option 0: counting begins automatically after reset.
// - Unprotected: wait and stop freeze the count, resume afterward.
// - Unprotected underflow: interrupt if action bit 0, reset if 1.
// - Protected: count low-speed oscillator edges directly, no prescaler.
// - Protected: counting never stops, even in wait or stop.
// - Protected underflow always gives reset, never interrupt.
// - Protection on forces oscillator on and action bit to reset.
// - Protection option bit 7 at 0 sets protection after reset.
// - Start option bit 0 is read only, never changed by writes.
// - Refresh outside acknowledge window is incorrect, fires action.
// - Protection set only by writing 0 then 1; clearing ignored.
`timescale 1ns/1ps
module wdcp_top (
	input  wire logic       I_CORE_CLK,       // Core clock, 25 MHz
	input  wire logic       I_ARST_N,         // Async reset, active low
	input  wire logic [7:0] I_OPT_MAIN,       // Main option byte
	input  wire logic [7:0] I_OPT_SECOND,     // Second option byte
	input  wire logic       I_LOCO_CLK,       // Low-speed oscillator clock
	input  wire logic       I_REFRESH_WR,     // Refresh register write
	input  wire logic [7:0] I_REFRESH_DATA,   // Refresh write data
	input  wire logic       I_START_WR,       // Start register write
	input  wire logic       I_PRESCALER_RATIO_SEL, // 0: /16, 1: /128
	input  wire logic       I_ACTION_WR,      // Action select write
	input  wire logic       I_ACTION_DATA,    // 0: interrupt, 1: reset
	input  wire logic       I_PROT_WR,        // Protection bit write
	input  wire logic       I_PROT_DATA,      // Protection write data
	input  wire logic       I_WAIT_MODE,      // Core in wait mode
	input  wire logic       I_STOP_MODE,      // Core in stop mode
	output logic            O_WDT_IRQ,        // Interrupt pulse
	output logic            O_WDT_RST,        // Reset request pulse
	output logic            O_LOCO_ON,        // Oscillator enable
	output logic            O_PROT_EN,        // Protection enable bit
	output logic            O_ACTION_SEL,     // Underflow action bit
	output logic            O_RUNNING,        // Counter running
	output logic [13:0]     O_COUNT           // Current count
);
	import wdcp_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	wdcp_state_t        state, next_state;
	wdcp_cfg_t          cfg, next_cfg;
	logic [CNT_W-1:0]   count, next_count;
	logic [PRE_W-1:0]   presc, next_presc;
	logic               prot_en, next_prot_en;
	logic               prot_armed, next_prot_armed;
	logic               action_sel, next_action_sel;
	logic               ref_armed, next_ref_armed;
	logic               irq, next_irq;
	logic               rst, next_rst;
	logic               loco_s1, loco_s2, loco_s3;

	logic [CNT_W-1:0]   period_val;
	logic [14:0]        win_lim;
	logic               loco_edge, presc_tick, tick, freeze;
	logic               uflow, refresh_seq, refresh_ok, refresh_bad;
	logic [1:0]         period_code;

	// ************************************************************
	// Oscillator synchroniser and edge detect
	// ************************************************************
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			loco_s1 <= 1'b0;
			loco_s2 <= 1'b0;
			loco_s3 <= 1'b0;
		end else begin
			loco_s1 <= I_LOCO_CLK;
			loco_s2 <= loco_s1;
			loco_s3 <= loco_s2;
		end
	end
	assign loco_edge = loco_s2 & ~loco_s3;

	// ************************************************************
	// Decodes and events
	// ************************************************************
	// Period field from the option pins while capturing, else the copy,
	// so the first load after reset already has the right count
	assign period_code = (state == WDCP_INIT)
		? I_OPT_SECOND[OPT_PERIOD_LSB +: 2] : cfg.period_sel;

	// Underflow count from the period field
	always_comb begin
		case (period_code)
			2'b00:   period_val = PERIOD_SEL_00;
			2'b01:   period_val = PERIOD_SEL_01;
			2'b10:   period_val = PERIOD_SEL_10;
			default: period_val = PERIOD_SEL_11;
		endcase
	end

	// Window limit: quarters of the period, counted toward underflow
	assign win_lim = 15'(({1'b0, period_val} + 15'h0001) >> 2)
		* 15'({13'h0000, cfg.window_sel} + 15'h0001);

	// Prescaler wraps at 16 or 128 core clocks
	assign presc_tick = (presc == (I_PRESCALER_RATIO_SEL ? PRE_LAST_128
		: PRE_LAST_16));
	assign freeze = ~prot_en & (I_WAIT_MODE | I_STOP_MODE);
	assign tick = (state == WDCP_RUN) & ~freeze
		& (prot_en ? loco_edge : presc_tick);
	assign uflow = tick & (count == COUNT_RST);
	assign refresh_seq = I_REFRESH_WR & ref_armed
		& (I_REFRESH_DATA == REFRESH_SECOND);
	assign refresh_ok = refresh_seq & (state == WDCP_RUN)
		& ({1'b0, count} < win_lim);
	assign refresh_bad = refresh_seq & (state == WDCP_RUN)
		& ~({1'b0, count} < win_lim);

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		next_state      = state;
		next_cfg        = cfg;
		next_count      = count;
		next_presc      = presc;
		next_prot_en    = prot_en;
		next_prot_armed = prot_armed;
		next_action_sel = action_sel;
		next_ref_armed  = ref_armed;
		next_irq        = 1'b0;
		next_rst        = 1'b0;
		case (state)
			WDCP_INIT: begin
				// Capture option bytes once; they are never written here
				next_cfg.prot_init      = ~I_OPT_MAIN[OPT_PROT_BIT];
				next_cfg.halt_after_rst = I_OPT_MAIN[OPT_START_BIT];
				next_cfg.period_sel     = I_OPT_SECOND[OPT_PERIOD_LSB +: 2];
				next_cfg.window_sel     = I_OPT_SECOND[OPT_WINDOW_LSB +: 2];
				next_prot_en = ~I_OPT_MAIN[OPT_PROT_BIT];
				next_count   = period_val;
				next_state = I_OPT_MAIN[OPT_START_BIT] ? WDCP_HALT
					: WDCP_RUN;
			end
			WDCP_HALT: begin
				next_count = period_val;
				if (I_START_WR)
					next_state = WDCP_RUN;
			end
			WDCP_RUN: begin
				// Prescaler only steps; refresh leaves it alone
				if (!freeze && !prot_en)
					next_presc = presc_tick ? PRE_RST
						: PRE_W'(presc + 7'h01);
				if (uflow || refresh_ok)
					next_count = period_val;
				else if (tick)
					next_count = CNT_W'(count - 14'h0001);
				if (uflow || refresh_bad) begin
					next_rst = prot_en | action_sel;
					next_irq = ~prot_en & ~action_sel;
				end
			end
			default: next_state = WDCP_INIT;
		endcase
		// Refresh arms on 00h; any other write disarms
		if (I_REFRESH_WR)
			next_ref_armed = (I_REFRESH_DATA == REFRESH_FIRST);
		// Protection: 0 arms, 1 after arm sets, clearing ignored
		if (I_PROT_WR) begin
			next_prot_armed = ~I_PROT_DATA;
			if (I_PROT_DATA && prot_armed)
				next_prot_en = 1'b1;
		end
		if (I_ACTION_WR)
			next_action_sel = I_ACTION_DATA;
		if (next_prot_en)
			next_action_sel = 1'b1;
	end

	// Registers
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state      <= WDCP_INIT;
			cfg        <= '0;
			count      <= COUNT_RST;
			presc      <= PRE_RST;
			prot_en    <= 1'b0;
			prot_armed <= 1'b0;
			action_sel <= 1'b0;
			ref_armed  <= 1'b0;
			irq        <= 1'b0;
			rst        <= 1'b0;
		end else begin
			state      <= next_state;
			cfg        <= next_cfg;
			count      <= next_count;
			presc      <= next_presc;
			prot_en    <= next_prot_en;
			prot_armed <= next_prot_armed;
			action_sel <= next_action_sel;
			ref_armed  <= next_ref_armed;
			irq        <= next_irq;
			rst        <= next_rst;
		end
	end

	// Outputs
	assign O_WDT_IRQ    = irq;
	assign O_WDT_RST    = rst;
	assign O_LOCO_ON    = prot_en;
	assign O_PROT_EN    = prot_en;
	assign O_ACTION_SEL = action_sel;
	assign O_RUNNING    = (state == WDCP_RUN);
	assign O_COUNT      = count;

	// ************************************************************
	// Assertions
	// ************************************************************
	a_presc_ratio: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_ARST_N)
		(tick && !prot_en && !I_PROT_WR) |=> presc == PRE_RST && !tick)
		else $error("prescaler did not restart after a tick");
	a_init_load: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_ARST_N)
		(state == WDCP_INIT) |=> count == period_val)
		else $error("counter not loaded after reset");
	a_halt_reload: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_ARST_N)
		(state == WDCP_HALT) |=> count == period_val)
		else $error("halted counter not at period value");
	a_refresh_load: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_ARST_N)
		(refresh_ok && !uflow) |=> count == period_val && !O_WDT_IRQ
			&& !O_WDT_RST)
		else $error("refresh did not reload counter");
	a_halt_hold: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_ARST_N)
		(state == WDCP_HALT && !I_START_WR) |=> state == WDCP_HALT
			&& $stable(presc))
		else $error("halted watchdog moved");
	a_freeze_hold: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_ARST_N)
		(state == WDCP_RUN && freeze && !refresh_ok) |=> $stable(count)
			&& $stable(presc))
		else $error("count moved in wait or stop");
	a_irq_path: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_ARST_N)
		(uflow && !prot_en && !action_sel) |=> O_WDT_IRQ && !O_WDT_RST)
		else $error("underflow interrupt missing");
	a_prot_reset: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_ARST_N)
		(uflow && prot_en) |=> O_WDT_RST && !O_WDT_IRQ)
		else $error("protected underflow not reset");
	a_prot_force: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_ARST_N)
		prot_en |-> action_sel && O_LOCO_ON)
		else $error("protection did not force reset action");
	a_prot_sticky: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_ARST_N)
		(prot_en && state != WDCP_INIT) |=> prot_en)
		else $error("protection bit cleared");
	a_window_bad: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_ARST_N)
		refresh_bad |=> (O_WDT_RST || O_WDT_IRQ)
			&& (count == $past(count) || ($past(tick)
			&& count == 14'($past(count) - 14'h0001))))
		else $error("early refresh not flagged");

endmodule : wdcp_top
